// ==== rtl/video_input_port_pin_control.sv ====
// Parallel video input, shared pin control, power-down and strap handling
`timescale 1ns/100ps
module video_input_port_pin_control
	import vip_pkg::*;
#(
	parameter logic [BUS_ADDR_W-1:0] BUS_ADDR_BASE = 7'h10 // Arbitrary base
) (
	input  wire logic                  clk,                 // System clock
	input  wire logic                  rst,                 // Async reset
	input  wire logic                  pix_clk,             // Pixel clock
	input  wire logic [ADDR_W-1:0]     reg_addr,            // Register addr
	input  wire logic [DATA_W-1:0]     reg_wdata,           // Write data
	input  wire logic                  reg_wr,              // Write strobe
	input  wire logic                  reg_rd,              // Read strobe
	output logic      [DATA_W-1:0]     reg_rdata,           // Read data
	input  wire logic [7:0]            red_in,              // Red pins
	input  wire logic [7:0]            green_in,            // Green pins
	input  wire logic [7:0]            blue_in,             // Blue pins
	input  wire logic                  hsync_in,            // Horizontal sync
	input  wire logic                  vertical_sync,       // Vertical sync
	input  wire logic                  pixel_valid,         // Data enable
	input  wire logic                  audio_bit_clock_in,  // Audio bit clock
	input  wire logic                  audio_word_clock_in, // Audio word clk
	input  wire logic                  audio_data_first,    // Audio data A
	output logic [23:0]                pix_rgb_out,         // Sampled pixel
	output logic                       pix_hsync_out,       // Filtered hsync
	output logic                       pix_vsync_out,       // Sampled vsync
	output logic                       pix_valid_out,       // Filtered valid
	output logic [AUD_W-1:0]           audio_out,           // Audio levels
	output logic                       audio_data_second,   // Audio data B
	output logic [GPO_N-1:0]           gpo_pin_out,         // Outputs 4..8
	output logic [GPO_N-1:0]           gpo_pin_oe_n,        // Drive enables
	output logic [GPIO_N-1:0]          gpio_out,            // GPIO 0..1 out
	output logic [GPIO_N-1:0]          gpio_oe_n,           // GPIO enables
	input  wire logic                  power_down_n,        // Power-down pin
	input  wire logic                  mode_strap,          // 18-bit strap
	input  wire logic [STRAP_W-1:0]    bus_address_strap,   // Address level
	output logic [BUS_ADDR_W-1:0]      bus_target_address,  // Bus address
	input  wire logic                  scl_in,              // Bus clock in
	output logic                       scl_out,             // Bus clock out
	output logic                       scl_oe_n,            // Bus clock oe
	input  wire logic                  sda_in,              // Bus data in
	output logic                       sda_out,             // Bus data out
	output logic                       sda_oe_n,            // Bus data oe
	output logic                       link_drive_p,        // Serial true
	output logic                       link_drive_n,        // Serial invert
	output logic                       pll_enable           // PLL run
);
	logic [PS_W-1:0]       pin_raw;
	logic [PS_W-1:0]       pin_q;
	logic                  powered_down;
	logic [DATA_W-1:0]     cfg_ff;
	logic [DATA_W-1:0]     gpo_ff;
	logic [DATA_W-1:0]     gpio_ff;
	logic                  strap_taken_ff;
	logic                  mode_strap_ff;
	logic [BUS_ADDR_W-1:0] addr_ff;
	logic                  link_p_ff;
	logic                  link_n_ff;
	logic                  pll_ff;
	logic [DATA_W-1:0]     rdata_ff;
	logic [DATA_W-1:0]     status;
	logic                  mode18;
	logic [GPO_N-1:0]      gpo_en;
	blue1_role_type        b1_role;
	logic [PC_W-1:0]       pcfg_raw;
	logic [PC_W-1:0]       pcfg;
	logic [PIX_W-1:0]      pos_cap_ff;
	logic [PIX_W-1:0]      neg_cap_ff;
	logic [PIX_W-1:0]      pix_sel;
	logic [23:0]           rgb_ff;
	logic                  vsync_ff;
	logic [AUD_W-1:0]      aud_q;
	logic [AUD_W-1:0]      aud_ff;

	// Pins from outside the register domain
	assign pin_raw = {bus_address_strap, red_in[1:0], pix_valid_out,
		mode_strap, sda_in, scl_in, power_down_n};

	level_sync #(.W(PS_W), .INIT(PS_RESET)) u_pin_sync (
		.clk (clk),
		.rst (rst),
		.d   (pin_raw),
		.q   (pin_q)
	);

	assign powered_down = !pin_q[PS_PDN];

	// Control registers; power-down returns them to defaults
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_ff  <= CONFIG_RESET;
			gpo_ff  <= GPO_RESET;
			gpio_ff <= GPIO_RESET;
		end else if (powered_down) begin
			cfg_ff  <= CONFIG_RESET;
			gpo_ff  <= GPO_RESET;
			gpio_ff <= GPIO_RESET;
		end else if (reg_wr) begin
			if (reg_addr == OFF_CONFIG)
				cfg_ff <= reg_wdata;
			if (reg_addr == OFF_GPO)
				gpo_ff <= reg_wdata;
			if (reg_addr == OFF_GPIO)
				gpio_ff <= reg_wdata;
		end
	end

	// Straps are taken once, on the first cycle after power-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_taken_ff <= 1'b0;
			mode_strap_ff  <= 1'b0;
			addr_ff        <= BUS_ADDR_BASE;
		end else if (powered_down) begin
			strap_taken_ff <= 1'b0;
		end else if (!strap_taken_ff) begin
			strap_taken_ff <= 1'b1;
			mode_strap_ff  <= pin_q[PS_MODE];
			addr_ff        <= BUS_ADDR_BASE + BUS_ADDR_W'(
				pin_q[PS_STRAP +: STRAP_W]);
		end
	end

	assign bus_target_address = addr_ff;

	// Serial drivers idle differential when up, both high when down
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link_p_ff <= 1'b1;
			link_n_ff <= 1'b1;
			pll_ff    <= 1'b0;
		end else begin
			link_p_ff <= 1'b1;
			link_n_ff <= powered_down;
			pll_ff    <= !powered_down;
		end
	end

	assign link_drive_p = link_p_ff;
	assign link_drive_n = link_n_ff;
	assign pll_enable   = pll_ff;

	// No bus engine here: the lines are only ever released, never driven
	assign scl_out  = 1'b0;
	assign scl_oe_n = 1'b1;
	assign sda_out  = 1'b0;
	assign sda_oe_n = 1'b1;

	assign mode18 = mode_strap_ff | cfg_ff[CFG_MODE18];
	assign gpo_en = gpo_ff[GPO_EN_LSB +: GPO_N];

	// Audio channel B wins the shared pin, then the output, then blue
	always_comb begin
		if (mode18 && cfg_ff[CFG_AUDIO2])
			b1_role = b1_audio;
		else if (gpo_en[1])
			b1_role = b1_gpo;
		else
			b1_role = b1_blue;
	end

	genvar g;
	generate
		for (g = 0; g < GPO_N; g++) begin : g_gpo
			assign gpo_pin_out[g] = gpo_ff[GPO_VAL_LSB + g];
			if (g == 1) begin : g_b1
				assign gpo_pin_oe_n[g] = (b1_role != b1_gpo);
			end else begin : g_other
				assign gpo_pin_oe_n[g] = !gpo_en[g];
			end
		end
	endgenerate

	assign gpio_out  = gpio_ff[GPIO_VAL_LSB +: GPIO_N];
	assign gpio_oe_n = ~gpio_ff[GPIO_EN_LSB +: GPIO_N];

	always_comb begin
		status                             = '0;
		status[ST_DOWN]                    = powered_down;
		status[ST_VALID]                   = pin_q[PS_VALID];
		status[ST_MODE18]                  = mode18;
		status[ST_SCL]                     = pin_q[PS_SCL];
		status[ST_SDA]                     = pin_q[PS_SDA];
		status[ST_GPIO_LSB +: GPIO_N]      = pin_q[PS_GPIO +: GPIO_N];
		status[ST_ADDR_LSB +: BUS_ADDR_W]  = addr_ff;
	end

	// Read data stand for one cycle only; unmapped offsets read zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata_ff <= '0;
		else if (!reg_rd || powered_down)
			rdata_ff <= '0;
		else begin
			unique case (reg_addr)
				OFF_CONFIG: rdata_ff <= cfg_ff;
				OFF_GPO:    rdata_ff <= gpo_ff;
				OFF_GPIO:   rdata_ff <= gpio_ff;
				OFF_STATUS: rdata_ff <= status;
				default:    rdata_ff <= '0;
			endcase
		end
	end

	assign reg_rdata = rdata_ff;

	// Config crossing into the pixel domain; it changes rarely, so
	// per-bit settling is acceptable
	assign pcfg_raw = {gpo_en[4:2], gpio_ff[GPIO_EN_LSB +: GPIO_N],
		b1_role == b1_audio, b1_role == b1_blue, gpo_en[0],
		powered_down, cfg_ff[CFG_FILT], cfg_ff[CFG_EDGE]};

	level_sync #(.W(PC_W), .INIT(PC_RESET)) u_cfg_sync (
		.clk (pix_clk),
		.rst (rst),
		.d   (pcfg_raw),
		.q   (pcfg)
	);

	// Video captured on both edges, the configured one is used
	always_ff @(posedge pix_clk or posedge rst) begin
		if (rst)
			pos_cap_ff <= '0;
		else
			pos_cap_ff <= {vertical_sync, hsync_in, pixel_valid,
				red_in, green_in, blue_in};
	end

	always_ff @(negedge pix_clk or posedge rst) begin
		if (rst)
			neg_cap_ff <= '0;
		else
			neg_cap_ff <= {vertical_sync, hsync_in, pixel_valid,
				red_in, green_in, blue_in};
	end

	assign pix_sel = pcfg[PC_EDGE] ? pos_cap_ff : neg_cap_ff;

	always_ff @(posedge pix_clk or posedge rst) begin
		if (rst) begin
			rgb_ff   <= '0;
			vsync_ff <= 1'b0;
		end else if (pcfg[PC_DOWN]) begin
			rgb_ff   <= '0;
			vsync_ff <= 1'b0;
		end else begin
			rgb_ff   <= pix_sel[23:0];
			vsync_ff <= pix_sel[26];
			if (pcfg[PC_RGPIO])
				rgb_ff[16] <= 1'b0;
			if (pcfg[PC_RGPIO + 1])
				rgb_ff[17] <= 1'b0;
			if (pcfg[PC_B0GPO])
				rgb_ff[0] <= 1'b0;
			if (!pcfg[PC_B1BLUE])
				rgb_ff[1] <= 1'b0;
		end
	end

	assign pix_rgb_out   = rgb_ff;
	assign pix_vsync_out = vsync_ff;

	// Index 0 filters pixel_valid, index 1 the horizontal sync
	strobe_if sif[2] ();
	generate
		for (g = 0; g < 2; g++) begin : g_filt
			assign sif[g].raw    = !pcfg[PC_DOWN] && pix_sel[24 + g];
			assign sif[g].enable = pcfg[PC_FILT];
			glitch_filter u_filt (
				.clk_pix (pix_clk),
				.rst     (rst),
				.s       (sif[g].filt)
			);
		end
	endgenerate

	assign pix_valid_out = sif[0].clean;
	assign pix_hsync_out = sif[1].clean;

	// Audio pins run on their own clocks, so they are synchronised
	level_sync #(.W(AUD_W), .INIT('0)) u_aud_sync (
		.clk (pix_clk),
		.rst (rst),
		.d   ({blue_in[1], audio_data_first, audio_word_clock_in,
			audio_bit_clock_in}),
		.q   (aud_q)
	);

	always_ff @(posedge pix_clk or posedge rst) begin
		if (rst)
			aud_ff <= '0;
		else if (pcfg[PC_DOWN])
			aud_ff <= '0;
		else
			aud_ff <= aud_q & {pcfg[PC_B1AUD], ~pcfg[PC_AGPO],
				~pcfg[PC_AGPO + 1], ~pcfg[PC_AGPO + 2]};
	end

	assign audio_out         = {1'b0, aud_ff[2:0]};
	assign audio_data_second = aud_ff[3];

	a_pdn_config: assert property (
		@(posedge clk) disable iff (rst)
		powered_down |=> cfg_ff == CONFIG_RESET && gpo_ff == GPO_RESET)
		else $error("registers not reset while powered down");

	a_pdn_drivers: assert property (
		@(posedge clk) disable iff (rst)
		powered_down |=> link_drive_p && link_drive_n && !pll_enable)
		else $error("drivers or PLL active while powered down");

	a_up_drivers: assert property (
		@(posedge clk) disable iff (rst)
		!powered_down [*2] |-> !link_drive_n && pll_enable)
		else $error("link not running while powered up");

	a_gpo_drive: assert property (
		@(posedge clk) disable iff (rst)
		(gpo_en[4] && !powered_down) |-> !gpo_pin_oe_n[4]
			&& gpo_pin_out[4] == gpo_ff[GPO_VAL_LSB + 4])
		else $error("output eight not driven from its register");

	a_audio_18bit: assert property (
		@(posedge clk) disable iff (rst)
		!gpo_pin_oe_n[1] |-> !(mode18 && cfg_ff[CFG_AUDIO2]))
		else $error("blue bit one driven while carrying audio");

	a_ignore_write: assert property (
		@(posedge clk) disable iff (rst)
		(powered_down && reg_wr) |=> cfg_ff == CONFIG_RESET)
		else $error("write accepted while powered down");

	a_addr_strap: assert property (
		@(posedge clk) disable iff (rst)
		$rose(strap_taken_ff) |-> bus_target_address ==
			BUS_ADDR_BASE + BUS_ADDR_W'($past(pin_q[PS_STRAP +: STRAP_W])))
		else $error("bus address does not follow the strap");

	a_bus_released: assert property (
		@(posedge clk) disable iff (rst)
		(!scl_oe_n |-> !scl_out) and (!sda_oe_n |-> !sda_out))
		else $error("control bus line driven high");

	a_read_once: assert property (
		@(posedge clk) disable iff (rst)
		!reg_rd |=> reg_rdata == '0)
		else $error("read data outside the answer cycle");

	a_edge_select: assert property (
		@(posedge pix_clk) disable iff (rst)
		(!pcfg[PC_DOWN] && pcfg[PC_EDGE]) |=>
			pix_rgb_out[23:18] == $past(pos_cap_ff[23:18]))
		else $error("pixel not taken from the rising edge capture");

	c_power_up: cover property (@(posedge clk) disable iff (rst)
		$fell(powered_down));
	c_config_write: cover property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == OFF_CONFIG && !powered_down);
	c_audio_second: cover property (@(posedge clk) disable iff (rst)
		b1_role == b1_audio);
	c_valid_rise: cover property (@(posedge pix_clk) disable iff (rst)
		$rose(pix_valid_out));
endmodule

// ==== rtl/vip_pkg.sv ====
// Shared constants and types for the video input port pin control block
package vip_pkg;
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 32;
	localparam logic [7:0]  OFF_CONFIG     = 8'h00;
	localparam logic [7:0]  OFF_GPO        = 8'h04;
	localparam logic [7:0]  OFF_GPIO       = 8'h08;
	localparam logic [7:0]  OFF_STATUS     = 8'h0c;
	// Config register fields
	localparam int          CFG_EDGE       = 0;
	localparam int          CFG_FILT       = 1;
	localparam int          CFG_MODE18     = 2;
	localparam int          CFG_AUDIO2     = 3;
	localparam logic [31:0] CONFIG_RESET   = 32'h0000_0003;
	localparam logic [31:0] GPO_RESET      = 32'h0000_0000;
	localparam logic [31:0] GPIO_RESET     = 32'h0000_0000;
	// Output register fields
	localparam int          GPO_N          = 5;
	localparam int          GPO_VAL_LSB    = 0;
	localparam int          GPO_EN_LSB     = 8;
	localparam int          GPIO_N         = 2;
	localparam int          GPIO_VAL_LSB   = 0;
	localparam int          GPIO_EN_LSB    = 4;
	// Status register fields
	localparam int          ST_DOWN        = 0;
	localparam int          ST_VALID       = 1;
	localparam int          ST_MODE18      = 2;
	localparam int          ST_SCL         = 3;
	localparam int          ST_SDA         = 4;
	localparam int          ST_GPIO_LSB    = 8;
	localparam int          ST_ADDR_LSB    = 16;
	// Pin synchroniser bundle in the register clock domain
	localparam int          PS_PDN         = 0;
	localparam int          PS_SCL         = 1;
	localparam int          PS_SDA         = 2;
	localparam int          PS_MODE        = 3;
	localparam int          PS_VALID       = 4;
	localparam int          PS_GPIO        = 5;
	localparam int          PS_STRAP       = 7;
	localparam int          PS_W           = 10;
	localparam logic [9:0]  PS_RESET       = 10'h000;
	// Config bundle crossing into the pixel clock domain
	localparam int          PC_EDGE        = 0;
	localparam int          PC_FILT        = 1;
	localparam int          PC_DOWN        = 2;
	localparam int          PC_B0GPO       = 3;
	localparam int          PC_B1BLUE      = 4;
	localparam int          PC_B1AUD       = 5;
	localparam int          PC_RGPIO       = 6;
	localparam int          PC_AGPO        = 8;
	localparam int          PC_W           = 11;
	localparam logic [10:0] PC_RESET       = 11'h017;
	// Timing and widths
	localparam int          FILTER_MIN_PCLK = 3;
	localparam int          FILT_CNT_W     = 2;
	localparam int          STRAP_W        = 3;
	localparam int          BUS_ADDR_W     = 7;
	localparam int          PIX_W          = 27;
	localparam int          AUD_W          = 4;
	typedef enum logic [1:0] {b1_blue, b1_audio, b1_gpo} blue1_role_type;
endpackage

// ==== rtl/strobe_if.sv ====
// Carrier between a control strobe and its pulse filter
`timescale 1ns/100ps
interface strobe_if;
	logic raw;
	logic enable;
	logic clean;
	modport filt (input raw, input enable, output clean);
	modport user (output raw, output enable, input clean);
endinterface

// ==== rtl/level_sync.sv ====
// Three-stage level synchroniser that accepts a change once stages agree
`timescale 1ns/100ps
module level_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk, // Destination clock
	input  wire logic         rst, // Async reset, active high
	input  wire logic [W-1:0] d,   // Asynchronous input
	output logic      [W-1:0] q    // Filtered synchronous level
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= INIT;
			s2_ff <= INIT;
			s3_ff <= INIT;
		end else begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Hold each bit until its second and third stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			q <= INIT;
		else
			q <= (s3_ff & ~(s2_ff ^ s3_ff)) | (q & (s2_ff ^ s3_ff));
	end
endmodule

// ==== rtl/glitch_filter.sv ====
// Minimum-width filter for one video control strobe
`timescale 1ns/100ps
module glitch_filter
	import vip_pkg::*;
(
	input  wire logic clk_pix, // Pixel clock
	input  wire logic rst,     // Async reset, active high
	strobe_if.filt    s        // Raw strobe in, filtered strobe out
);
	logic [FILT_CNT_W-1:0] cnt_ff;
	logic                  clean_ff;

	assign s.clean = clean_ff;

	always_ff @(posedge clk_pix or posedge rst) begin
		if (rst) begin
			cnt_ff   <= '0;
			clean_ff <= 1'b0;
		end else if (s.raw == clean_ff) begin
			cnt_ff <= '0;
		end else if (!s.enable) begin
			clean_ff <= s.raw;
			cnt_ff   <= '0;
		end else if (cnt_ff == FILT_CNT_W'(FILTER_MIN_PCLK - 1)) begin
			clean_ff <= s.raw;
			cnt_ff   <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	a_filter_min_width: assert property (
		@(posedge clk_pix) disable iff (rst)
		($changed(clean_ff) && $past(s.enable, 1) && $past(s.enable, 2)
			&& $past(s.enable, 3))
		|-> ($past(s.raw, 1) == clean_ff && $past(s.raw, 2) == clean_ff
			&& $past(s.raw, 3) == clean_ff))
		else $error("filtered strobe changed after a short pulse");

	a_filter_bypass: assert property (
		@(posedge clk_pix) disable iff (rst)
		(!s.enable && s.raw != clean_ff) |=> clean_ff == $past(s.raw))
		else $error("unfiltered strobe did not follow its input");

	c_short_pulse_dropped: cover property (
		@(posedge clk_pix) disable iff (rst)
		s.enable && s.raw != clean_ff ##1 s.raw == clean_ff);
endmodule

// ==== sim/video_source.sv ====
// Behavioural parallel video and audio source for the pin control block
`timescale 1ns/100ps
module video_source (
	input  wire logic       pix_clk, // Pixel clock
	output logic      [7:0] red,     // Red pins
	output logic      [7:0] green,   // Green pins
	output logic      [7:0] blue,    // Blue pins
	output logic            hsync,   // Horizontal sync
	output logic            vsync,   // Vertical sync
	output logic            valid,   // Pixel valid strobe
	output logic      [2:0] audio    // {data, word clock, bit clock}
);
	initial begin
		{red, green, blue} = 24'h000000;
		{hsync, vsync, valid} = 3'h0;
		audio = 3'h0;
	end
	// Levels change just after a rising edge and then hold
	task automatic set_pix(input logic [23:0] v, input logic [2:0] a,
		input logic vs);
		@(posedge pix_clk);
		{red, green, blue} <= v;
		audio <= a;
		vsync <= vs;
	endtask
	// Vertical sync moves on the same edge as the pixel and audio levels
	// A pulse is two toggles of both strobes, then a quiet window
	task automatic pulse(input int w);
		@(posedge pix_clk);
		{valid, hsync} <= 2'b11;
		repeat (w) @(posedge pix_clk);
		{valid, hsync} <= 2'b00;
		repeat (130) @(posedge pix_clk);
	endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking testbench for the video input port pin control block
`timescale 1ns/100ps
module tb_top;
	import vip_pkg::*;
	localparam logic [6:0] BASE = 7'h10;
	logic                  clk, rst, pix_clk, reg_wr, reg_rd;
	logic                  power_down_n, hs, vs, pv, pvo, ad2;
	logic                  hso, vso, mstrap;
	logic [1:0]            seen;
	logic                  scl_o, scl_oe_n, sda_o, sda_oe_n, lp, ln, pll;
	logic [ADDR_W-1:0]     reg_addr;
	logic [DATA_W-1:0]     reg_wdata, reg_rdata, rdv, v;
	logic [STRAP_W-1:0]    strap;
	logic [7:0]            red, green, blue;
	logic [2:0]            aud, a;
	logic [23:0]           rgb_o;
	logic [AUD_W-1:0]      aud_o;
	logic [GPO_N-1:0]      gpo_o, gpo_oe_n;
	logic [GPIO_N-1:0]     gpio_o, gpio_oe_n;
	logic [BUS_ADDR_W-1:0] taddr;
	logic [31:0]           seed;
	int                    errors, checked, cycles;
	// Open-drain lines float high through the board pull-ups
	wire scl = scl_oe_n ? 1'b1 : scl_o;
	wire sda = sda_oe_n ? 1'b1 : sda_o;

	video_source src_inst (.pix_clk(pix_clk), .red(red), .green(green),
		.blue(blue), .hsync(hs), .vsync(vs), .valid(pv), .audio(aud));
	video_input_port_pin_control #(.BUS_ADDR_BASE(BASE))
		video_input_port_pin_control_inst (
		.clk(clk), .rst(rst), .pix_clk(pix_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .red_in(red), .green_in(green),
		.blue_in(blue), .hsync_in(hs), .vertical_sync(vs),
		.pixel_valid(pv), .audio_bit_clock_in(aud[0]),
		.audio_word_clock_in(aud[1]), .audio_data_first(aud[2]),
		.pix_rgb_out(rgb_o), .pix_hsync_out(hso), .pix_vsync_out(vso),
		.pix_valid_out(pvo), .audio_out(aud_o), .audio_data_second(ad2),
		.gpo_pin_out(gpo_o), .gpo_pin_oe_n(gpo_oe_n), .gpio_out(gpio_o),
		.gpio_oe_n(gpio_oe_n), .power_down_n(power_down_n),
		.mode_strap(mstrap), .bus_address_strap(strap),
		.bus_target_address(taddr), .scl_in(scl), .scl_out(scl_o),
		.scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_o),
		.sda_oe_n(sda_oe_n), .link_drive_p(lp), .link_drive_n(ln),
		.pll_enable(pll));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		pix_clk = 1'b0;
		#3.3;
		forever #7.5 pix_clk = ~pix_clk;
	end
	always @(posedge pix_clk) begin
		if (pvo === 1'b1) seen[0] <= 1'b1;
		if (hso === 1'b1) seen[1] <= 1'b1;
	end
	// A hang ends the run with a counted mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Audio levels pass unless their pin is claimed as an output
	function automatic logic [31:0] exp_aud(logic [2:0] a, logic [4:0] en);
		return {29'h0, a[2] & ~en[2], a[1] & ~en[3], a[0] & ~en[4]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Let the written register settle before anyone looks at it
		#1;
	endtask
	task automatic rd(input logic [7:0] ad);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rdv = reg_rdata;
	endtask
	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
		rd(ad);
		chk(rdv, e);
	endtask
	task automatic pclks(input int n);
		repeat (n) @(posedge pix_clk);
		@(posedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		seed = 32'd18;
		{reg_wr, reg_rd, seen, mstrap} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		power_down_n = 1'b1;
		v = xs();
		strap = v[STRAP_W-1:0];
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		rd_chk(OFF_CONFIG, CONFIG_RESET);
		rd_chk(OFF_GPO, GPO_RESET);
		rd_chk(OFF_GPIO, GPIO_RESET);
		rd_chk(8'h10, 32'h0);
		chk(taddr, BASE + 7'(strap));
		chk({lp, ln, pll}, 3'b101);
		chk({scl_oe_n, sda_oe_n}, 2'b11);
		rd(OFF_STATUS);
		chk(rdv[4:3], 2'b11);
		$display("reset and strap test finished");
		// Both sampling edges must deliver a steady pixel
		for (int e = 0; e < 2; e++) begin
			wr(OFF_CONFIG, 32'(e + 2));
			v = xs();
			a = v[26:24];
			src_inst.set_pix(v[23:0], a, 1'b0);
			pclks(12);
			chk(rgb_o, v[23:0]);
			chk(aud_o, exp_aud(a, 5'h00));
		end
		wr(OFF_CONFIG, CONFIG_RESET);
		$display("pixel sampling test finished");
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 32'h1f1f : xs() & 32'h1f1f;
			wr(OFF_GPO, v);
			chk(gpo_o, v[4:0]);
			chk(gpo_oe_n, 5'(~v[12:8]));
			pclks(8);
			chk(aud_o, exp_aud(a, v[12:8]));
		end
		wr(OFF_GPO, 32'h0);
		v = xs() & 32'h33;
		wr(OFF_GPIO, v);
		chk(gpio_o, v[1:0]);
		chk(gpio_oe_n, 2'(~v[5:4]));
		rd(OFF_STATUS);
		chk(rdv[9:8], red[1:0]);
		wr(OFF_GPIO, 32'h0);
		$display("shared output test finished");
		// Two-clock pulses are the widest that must be dropped
		for (int w = 1; w < 5; w++) begin
			seen = 2'b00;
			src_inst.pulse(w);
			chk(seen, {2{w >= FILTER_MIN_PCLK}});
		end
		wr(OFF_CONFIG, 32'h1);
		pclks(6);
		seen = 2'b00;
		src_inst.pulse(1);
		chk(seen, 2'b11);
		$display("strobe filter test finished");
		wr(OFF_CONFIG, 32'hf);
		v = xs() | 32'h2;
		src_inst.set_pix(v[23:0], a, 1'b1);
		pclks(12);
		chk(vso, 1'b1);
		chk(ad2, 1'b1);
		chk(rgb_o[1], 1'b0);
		rd(OFF_STATUS);
		chk(rdv[2], 1'b1);
		wr(OFF_CONFIG, CONFIG_RESET);
		wr(OFF_GPO, 32'h0202);
		pclks(12);
		chk(ad2, 1'b0);
		chk(rgb_o[1], 1'b0);
		chk(gpo_oe_n, 5'h1d);
		$display("blue bit one test finished");
		wr(OFF_CONFIG, 32'h0);
		power_down_n <= 1'b0;
		mstrap <= 1'b1;
		pclks(12);
		chk({lp, ln, pll}, 3'b110);
		chk(rgb_o, 24'h0);
		chk(vso, 1'b0);
		rd_chk(OFF_STATUS, 32'h0);
		power_down_n <= 1'b1;
		repeat (10) @(posedge clk);
		chk({lp, ln, pll}, 3'b101);
		rd_chk(OFF_CONFIG, CONFIG_RESET);
		rd_chk(OFF_GPO, GPO_RESET);
		// The 18-bit strap is taken again as the block comes back up
		rd(OFF_STATUS);
		chk(rdv[2], 1'b1);
		$display("power down test finished");
		tally_and_finish();
	end
endmodule
